// file: design/mtc_pkg.sv
// package for the translation control register bank
// assumes one processor clock; host reaches registers by coprocessor moves
package mtc_pkg;

  // ****************************************************
  // register selects on the coprocessor register port
  // ****************************************************
  localparam logic [1:0] REG_CACHE_STATUS = 2'h0;
  localparam logic [1:0] REG_TRANS_CTRL = 2'h1;
  localparam logic [1:0] REG_CUR_LEVEL = 2'h2;
  localparam logic [1:0] REG_CALLER_LEVEL = 2'h3;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int TC_ENABLE_BIT = 31;
  localparam int TC_SRE_BIT = 25;
  localparam int TC_FCL_BIT = 24;
  localparam int TC_PS_LSB = 20;
  localparam int TC_IS_LSB = 16;
  localparam int TC_TIA_LSB = 12;
  localparam int TC_TIB_LSB = 8;
  localparam int TC_TIC_LSB = 4;
  localparam int TC_TID_LSB = 0;
  localparam logic [31:0] TC_IMPL_MASK = 32'h83ffffff;
  localparam int CS_PURGED_BIT = 15;
  localparam int CS_LOCKWARN_BIT = 14;
  localparam logic [7:0] LEVEL_IMPL_MASK = 8'he0;
  localparam logic [5:0] TC_SUM_TARGET = 6'h20;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [31:0] TC_RESET = 32'h00000000;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [2:0] ALIAS_RESET = 3'h0;

  // ****************************************************
  // operations presented by the host
  // ****************************************************
  typedef enum logic [2:0] {
    MTC_OP_NONE,
    MTC_OP_MOVE,
    MTC_OP_RESTORE,
    MTC_OP_PROBE,
    MTC_OP_PRELOAD,
    MTC_OP_CALL,
    MTC_OP_RETURN
  } mtc_op_t;

  typedef struct packed {
    logic valid;
    mtc_op_t op;
    logic write;
    logic [1:0] sel;
    logic [31:0] data;
    logic callType1;
    logic [7:0] newLevel;
  } mtc_req_t;

  typedef struct packed {
    logic done;
    logic [31:0] rdata;
    logic cfgErr;
    logic opErr;
  } mtc_rsp_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] fc;
    logic cpuSpace;
    logic selfAccess;
    logic strobe;
  } mtc_bus_t;

  typedef struct packed {
    logic supervisor;
    logic dmaRoot;
  } mtc_walk_t;

  function automatic logic [5:0] mtc_tc_sum(input logic [31:0] v);
    mtc_tc_sum = 6'(v[TC_PS_LSB +: 4]) + 6'(v[TC_IS_LSB +: 4]) + 6'(v[TC_TIA_LSB +: 4])
      + 6'(v[TC_TIB_LSB +: 4]) + 6'(v[TC_TIC_LSB +: 4]) + 6'(v[TC_TID_LSB +: 4]);
  endfunction

endpackage

// file: design/mtc_regs.sv
// translation control, cache status and access level registers
// assumes host requests arrive synchronous to core_clk, one cycle each

// Contract
// - cache status 16-bit read-only, refreshed on user root writes
// - low three bits show current alias
// - purge flag set on flushing write, else cleared
// - lock warning when all but one locked
// - no more locks while warning set
// - control 32-bit, unimplemented bits read zero
// - write with enable clear flushes whole cache
// - enabled write checks field sum equals 32
// - failed check stores value, enable forced clear
// - disabled: probe, preload, type 1 call and return take exception
// - disabled: pass address, strobe, inhibit cpu space
// - reset clears enable; set only from clear
// - supervisor root select follows SRE bit on supervisor searches
// - function code index picks first lookup
// - dma root searches always use function code
// - page size codes 8 to F
// - page size top bit zero raises exception
// - initial shift skips upper address bits
// - level widths in order, zero ends search
// - current level upper three bits, loaded by ops
// - level check aborts violating bus cycle
// - caller level loaded from current on call
module mtc_regs #(
  parameter int CACHE_ENTRIES = 64
) (
  input wire logic core_clk, // processor clock
  input wire logic rst, // async reset, active high
  input wire logic clkEn, // freezes all state when low
  input wire mtc_pkg::mtc_req_t req, // host register request
  output mtc_pkg::mtc_rsp_t rsp, // host answer
  input wire logic userRootWrite, // user root pointer written
  input wire logic userRootFlush, // that write purged cache entries
  input wire logic [2:0] aliasIn, // internal task alias
  input wire logic [$clog2(CACHE_ENTRIES+1)-1:0] lockedCount, // locked cache entries
  input wire logic lockRequest, // descriptor asks to lock
  output logic lockGrant, // entry may be locked
  output logic cacheFlushAll, // pulse: flush whole cache
  input wire mtc_pkg::mtc_walk_t walk, // table search context
  output logic useSupervisorRoot, // search via supervisor root
  output logic fcLookupFirst, // first level uses function code
  output logic [3:0] pageSize, // page size code
  output logic [3:0] initialShift, // skipped upper bits
  output logic [15:0] levelWidths, // a,b,c,d widths
  output logic [4:0] firstIndexTop, // top bit of first address index
  input wire mtc_pkg::mtc_bus_t logical, // logical bus cycle
  output logic [31:0] physAddr, // physical address
  output logic physicalStrobe, // physical strobe
  output logic cacheInhibitOut, // cache inhibit
  input wire logic levelCheckEn, // access level checking on
  input wire logic [2:0] addrLevel, // level field from address
  output logic busAbort // abort current cycle
);
  import mtc_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  logic [31:0] transCtrl;
  logic [7:0] curLevel;
  logic [7:0] callerLevel;
  logic purged;
  logic [2:0] aliasShown;

  // ****************************************************
  // decode
  // ****************************************************
  wire logic reqAct = clkEn && req.valid;
  wire logic regWr = reqAct && req.write && (req.op == MTC_OP_MOVE || req.op == MTC_OP_RESTORE);
  wire logic tcWr = regWr && req.sel == REG_TRANS_CTRL;
  wire logic curWr = regWr && req.sel == REG_CUR_LEVEL;
  wire logic callerWr = regWr && req.sel == REG_CALLER_LEVEL;
  wire logic enabled = transCtrl[TC_ENABLE_BIT];
  wire logic [31:0] tcIn = req.data & TC_IMPL_MASK;
  wire logic wantEnable = tcIn[TC_ENABLE_BIT];
  wire logic sumBad = wantEnable && mtc_tc_sum(tcIn) != TC_SUM_TARGET;
  wire logic psBad = wantEnable && !tcIn[TC_PS_LSB + 3];
  wire logic cfgFail = sumBad || psBad;
  wire logic enAllowed = !enabled;
  wire logic tcAccept = tcWr && !(wantEnable && !enAllowed);
  wire logic [31:0] tcStore = cfgFail ? (tcIn & ~(32'h1 << TC_ENABLE_BIT)) : tcIn;
  wire logic gatedOp = req.op == MTC_OP_PROBE || req.op == MTC_OP_PRELOAD
    || ((req.op == MTC_OP_CALL || req.op == MTC_OP_RETURN) && req.callType1);
  wire logic opRefused = reqAct && gatedOp && !enabled;
  wire logic lvlOp = reqAct && enabled && (req.op == MTC_OP_CALL || req.op == MTC_OP_RETURN);
  wire logic lockWarn = lockedCount >= ($clog2(CACHE_ENTRIES+1))'(CACHE_ENTRIES - 1);
  wire logic [15:0] csView = {purged, lockWarn, 11'h000, aliasShown};

  // ****************************************************
  // read mux
  // ****************************************************
  logic [31:0] readVal;
  always_comb begin
    unique case (req.sel)
      REG_CACHE_STATUS: readVal = {16'h0000, csView};
      REG_TRANS_CTRL: readVal = transCtrl & TC_IMPL_MASK;
      REG_CUR_LEVEL: readVal = {24'h000000, curLevel & LEVEL_IMPL_MASK};
      REG_CALLER_LEVEL: readVal = {24'h000000, callerLevel & LEVEL_IMPL_MASK};
    endcase
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      transCtrl <= TC_RESET;
      curLevel <= LEVEL_RESET;
      callerLevel <= LEVEL_RESET;
      purged <= 1'b0;
      aliasShown <= ALIAS_RESET;
      rsp <= '0;
      cacheFlushAll <= 1'b0;
    end else if (clkEn) begin
      rsp.done <= reqAct;
      rsp.rdata <= (reqAct && !req.write) ? readVal : 32'h00000000;
      rsp.cfgErr <= tcAccept && cfgFail;
      rsp.opErr <= opRefused;
      cacheFlushAll <= tcAccept && !tcStore[TC_ENABLE_BIT];
      if (tcAccept) transCtrl <= tcStore;
      if (userRootWrite) begin
        purged <= userRootFlush;
        aliasShown <= aliasIn;
      end
      if (curWr) curLevel <= req.data[7:0] & LEVEL_IMPL_MASK;
      else if (lvlOp) curLevel <= req.newLevel & LEVEL_IMPL_MASK;
      if (callerWr) callerLevel <= req.data[7:0] & LEVEL_IMPL_MASK;
      else if (lvlOp && req.op == MTC_OP_CALL) callerLevel <= curLevel;
    end
  end

  // ****************************************************
  // translation configuration outputs
  // ****************************************************
  assign lockGrant = lockRequest && !lockWarn;
  assign useSupervisorRoot = walk.supervisor && transCtrl[TC_SRE_BIT];
  assign fcLookupFirst = walk.dmaRoot || transCtrl[TC_FCL_BIT];
  assign pageSize = transCtrl[TC_PS_LSB +: 4];
  assign initialShift = transCtrl[TC_IS_LSB +: 4];
  assign levelWidths = transCtrl[15:0];
  assign firstIndexTop = 5'(5'd31 - 5'(transCtrl[TC_IS_LSB +: 4]));

  // ****************************************************
  // bypass path while disabled, and level check abort
  // ****************************************************
  assign physAddr = logical.addr;
  assign physicalStrobe = logical.strobe && !logical.cpuSpace && !enabled;
  assign cacheInhibitOut = logical.strobe && logical.cpuSpace && !logical.selfAccess && !enabled;
  assign busAbort = levelCheckEn && logical.strobe && (addrLevel < curLevel[7:5]);

  // ****************************************************
  // checks: control word
  // ****************************************************
  enable_guard_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && tcWr && enabled && wantEnable |=> $stable(transCtrl))
    else $error("control rewritten while enabled");

  cfg_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && tcAccept && cfgFail |=> rsp.cfgErr && !transCtrl[TC_ENABLE_BIT])
    else $error("failed check left translation enabled");

  cfg_store_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && tcAccept && cfgFail |=> transCtrl[30:0] == $past(tcIn[30:0]))
    else $error("failed check dropped written fields");

  tc_store_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && tcAccept && !cfgFail |=> transCtrl == $past(tcIn))
    else $error("accepted control write not stored");

  impl_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    (transCtrl & ~TC_IMPL_MASK) == 32'h00000000)
    else $error("unimplemented control bits set");

  sum_check_a: assert property (@(posedge core_clk) disable iff (rst)
    rsp.cfgErr |-> $past(mtc_tc_sum(tcIn)) != TC_SUM_TARGET || !$past(tcIn[TC_PS_LSB + 3]))
    else $error("exception without bad sum");

  good_write_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && tcAccept && wantEnable && !cfgFail |=> !rsp.cfgErr && transCtrl[TC_ENABLE_BIT])
    else $error("consistent control write refused");

  no_err_off_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && tcWr && !wantEnable |=> !rsp.cfgErr)
    else $error("exception on disabled write");

  cfg_only_tc_a: assert property (@(posedge core_clk) disable iff (rst)
    rsp.cfgErr |-> $past(tcWr))
    else $error("exception without control write");

  ps_check_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && tcAccept && wantEnable && !tcIn[TC_PS_LSB + 3] |=> rsp.cfgErr)
    else $error("page size top bit clear not flagged");

  page_range_a: assert property (@(posedge core_clk) disable iff (rst)
    enabled |-> pageSize[3])
    else $error("enabled with page size below 256");

  flush_all_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && tcAccept && !wantEnable |=> cacheFlushAll)
    else $error("disabled write did not flush");

  flush_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    cacheFlushAll |-> $past(clkEn && tcAccept))
    else $error("flush without control write");

  no_flush_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !tcAccept |=> !cacheFlushAll)
    else $error("stray cache flush");

  // ****************************************************
  // checks: cache status and locking
  // ****************************************************
  purge_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && userRootWrite |=> csView[CS_PURGED_BIT] == $past(userRootFlush) && csView[2:0] == $past(aliasIn))
    else $error("purge flag or alias wrong");

  alias_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !userRootWrite |=> $stable(aliasShown) && $stable(purged))
    else $error("status changed without root write");

  status_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reqAct && !req.write && req.sel == REG_CACHE_STATUS |=> rsp.rdata == {16'h0000, $past(csView)})
    else $error("status read wrong");

  status_ro_a: assert property (@(posedge core_clk) disable iff (rst)
    regWr && req.sel == REG_CACHE_STATUS && !userRootWrite |=> $stable(purged) && $stable(aliasShown))
    else $error("status register written");

  lock_warn_a: assert property (@(posedge core_clk) disable iff (rst)
    int'(lockedCount) >= CACHE_ENTRIES - 1 |-> csView[CS_LOCKWARN_BIT])
    else $error("lock warning missing");

  lock_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    int'(lockedCount) < CACHE_ENTRIES - 1 |-> !csView[CS_LOCKWARN_BIT])
    else $error("lock warning too early");

  lock_block_a: assert property (@(posedge core_clk) disable iff (rst)
    csView[CS_LOCKWARN_BIT] |-> !lockGrant)
    else $error("lock granted under warning");

  lock_pass_a: assert property (@(posedge core_clk) disable iff (rst)
    lockRequest && !csView[CS_LOCKWARN_BIT] |-> lockGrant)
    else $error("lock refused without warning");

  // ****************************************************
  // checks: gated operations
  // ****************************************************
  refuse_op_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && req.valid && req.op == MTC_OP_PROBE && !enabled |=> rsp.opErr)
    else $error("probe allowed while disabled");

  refuse_load_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && req.valid && req.op == MTC_OP_PRELOAD && !enabled |=> rsp.opErr)
    else $error("preload allowed while disabled");

  allow_op_a: assert property (@(posedge core_clk) disable iff (rst)
    reqAct && gatedOp && enabled |=> !rsp.opErr)
    else $error("operation refused while enabled");

  // ****************************************************
  // checks: access levels
  // ****************************************************
  caller_load_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && lvlOp && req.op == MTC_OP_CALL && !callerWr |=> callerLevel == $past(curLevel))
    else $error("caller level not loaded");

  caller_write_a: assert property (@(posedge core_clk) disable iff (rst)
    callerWr |=> callerLevel == ($past(req.data[7:0]) & LEVEL_IMPL_MASK))
    else $error("caller level move lost");

  level_low_a: assert property (@(posedge core_clk) disable iff (rst)
    (curLevel[4:0] == 5'h00) && (callerLevel[4:0] == 5'h00))
    else $error("unimplemented level bits set");

  cur_write_a: assert property (@(posedge core_clk) disable iff (rst)
    curWr |=> curLevel == ($past(req.data[7:0]) & LEVEL_IMPL_MASK))
    else $error("current level move lost");

  cur_call_a: assert property (@(posedge core_clk) disable iff (rst)
    lvlOp && !curWr |=> curLevel == ($past(req.newLevel) & LEVEL_IMPL_MASK))
    else $error("current level not loaded by call");

  level_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !curWr && !lvlOp |=> $stable(curLevel))
    else $error("current level changed unasked");

  level_abort_a: assert property (@(posedge core_clk) disable iff (rst)
    levelCheckEn && logical.strobe && addrLevel < curLevel[7:5] |-> busAbort)
    else $error("violation not aborted");

  no_abort_a: assert property (@(posedge core_clk) disable iff (rst)
    !levelCheckEn |-> !busAbort)
    else $error("abort with checking off");

  // ****************************************************
  // checks: search setup and bypass
  // ****************************************************
  sup_root_a: assert property (@(posedge core_clk) disable iff (rst)
    walk.supervisor |-> useSupervisorRoot == transCtrl[TC_SRE_BIT])
    else $error("supervisor root select wrong");

  user_root_a: assert property (@(posedge core_clk) disable iff (rst)
    !walk.supervisor |-> !useSupervisorRoot)
    else $error("user access on supervisor root");

  fc_index_a: assert property (@(posedge core_clk) disable iff (rst)
    !walk.dmaRoot |-> fcLookupFirst == transCtrl[TC_FCL_BIT])
    else $error("function code lookup select wrong");

  dma_lookup_a: assert property (@(posedge core_clk) disable iff (rst)
    walk.dmaRoot |-> fcLookupFirst)
    else $error("dma search without function code");

  shift_top_a: assert property (@(posedge core_clk) disable iff (rst)
    {1'b0, firstIndexTop} + {2'b00, initialShift} == 6'd31)
    else $error("first index top wrong");

  bypass_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
    enabled |-> !physicalStrobe && !cacheInhibitOut)
    else $error("bypass strobe while enabled");

  bypass_pass_a: assert property (@(posedge core_clk) disable iff (rst)
    !enabled && logical.strobe && !logical.cpuSpace |-> physicalStrobe && physAddr == logical.addr)
    else $error("bypass cycle not passed");

  inhibit_cpu_a: assert property (@(posedge core_clk) disable iff (rst)
    !enabled && logical.strobe && logical.cpuSpace && !logical.selfAccess |-> cacheInhibitOut)
    else $error("cpu space cycle not inhibited");
endmodule

// file: verif/mtc_host.sv
// host processor model: one coprocessor register request at a time
// assumes the device answers with done one edge after taking a request
module mtc_host
  import mtc_pkg::*;
(
  input wire logic core_clk, // processor clock
  input wire mtc_pkg::mtc_rsp_t rsp, // device answer
  output mtc_pkg::mtc_req_t req // request to device
);
  timeunit 1ns;
  timeprecision 1ps;
  mtc_rsp_t got;
  initial req = '0;
  // ****************************************************
  // request driven at falling edge, held over taking edge
  // ****************************************************
  task automatic xfer(input mtc_op_t op, input logic wr, input logic [1:0] sel,
    input logic [31:0] d, input logic [7:0] lvl = 8'h00);
    @(negedge core_clk);
    req <= '{1'b1, op, wr, sel, d, 1'b1, lvl};
    @(negedge core_clk);
    // answer stands for one cycle only, take it now
    got = rsp;
    req.valid <= 1'b0;
  endtask
endmodule

// file: verif/tb_top.sv
// testbench for the translation control register bank
// assumes mtc_host drives requests; reference model kept in integers here
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mtc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic userRootWrite = 1'b0, userRootFlush = 1'b0, lockRequest = 1'b0, levelCheckEn = 1'b0;
  logic [2:0] aliasIn = 3'h0, addrLevel = 3'h0;
  logic [6:0] lockedCount = 7'h00;
  mtc_walk_t walk = '0;
  mtc_bus_t logical = '0;
  mtc_req_t req;
  mtc_rsp_t rsp;
  logic lockGrant, cacheFlushAll, useSupervisorRoot, fcLookupFirst, physicalStrobe, cacheInhibitOut, busAbort;
  logic [3:0] pageSize, initialShift;
  logic [15:0] levelWidths;
  logic [4:0] firstIndexTop;
  logic [31:0] physAddr;
  int bad_count = 0, compares = 0, cycles = 0, tcM = 0, curM = 0, calM = 0;
  always #4 core_clk = ~core_clk;
  mtc_host mtc_host_i (.core_clk, .rsp, .req);
  mtc_regs mtc_regs_i (.core_clk, .rst, .clkEn(1'b1), .req, .rsp, .userRootWrite, .userRootFlush, .aliasIn,
    .lockedCount, .lockRequest, .lockGrant, .cacheFlushAll, .walk, .useSupervisorRoot, .fcLookupFirst,
    .pageSize, .initialShift, .levelWidths, .firstIndexTop, .logical, .physAddr, .physicalStrobe,
    .cacheInhibitOut, .levelCheckEn, .addrLevel, .busAbort);
  // ****************************************************
  // checking helpers
  // ****************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic rd(input logic [1:0] s, input int exp);
    mtc_host_i.xfer(MTC_OP_MOVE, 1'b0, s, 32'h0);
    chk(mtc_host_i.got.rdata, exp);
  endtask
  task automatic wtc(input logic [31:0] d);
    logic [31:0] m;
    int s;
    logic e;
    m = d & TC_IMPL_MASK;
    s = m[23:20] + m[19:16] + m[15:12] + m[11:8] + m[7:4] + m[3:0];
    e = m[31] && !tcM[31] && (s != 32 || !m[23]);
    if (!(m[31] && tcM[31])) tcM = e ? m & 32'h7fffffff : m;
    mtc_host_i.xfer(MTC_OP_MOVE, 1'b1, REG_TRANS_CTRL, m);
    chk(mtc_host_i.got.cfgErr, e);
    chk(cacheFlushAll, !tcM[31]);
    rd(REG_TRANS_CTRL, tcM);
  endtask
  task automatic ops();
    logic [7:0] lv;
    for (int k = 3; k < 7; k++) begin
      lv = 8'($urandom);
      mtc_host_i.xfer(mtc_op_t'(k), 1'b0, REG_CUR_LEVEL, 32'h0, lv);
      chk(mtc_host_i.got.opErr, !tcM[31]);
      if (k == 5 && tcM[31]) calM = curM;
      if (k > 4 && tcM[31]) curM = lv & 8'he0;
    end
    rd(REG_CUR_LEVEL, curM);
    rd(REG_CALLER_LEVEL, calM);
  endtask
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    void'($urandom(81645));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    rd(REG_TRANS_CTRL, 0);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk) logical = '{$urandom, 4'($urandom), 1'($urandom), 1'($urandom), 1'b1};
      #1 chk(physAddr, logical.addr);
      chk(physicalStrobe, !logical.cpuSpace);
      chk(cacheInhibitOut, logical.cpuSpace && !logical.selfAccess);
    end
    ops();
    aliasIn = 3'($urandom);
    lockedCount = 7'd63;
    for (int f = 1; f >= 0; f--) begin
      userRootFlush = f[0];
      userRootWrite = 1'b1;
      @(negedge core_clk) userRootWrite = 1'b0;
      rd(REG_CACHE_STATUS, {f[0], 1'b1, 11'h000, aliasIn});
    end
    lockRequest = 1'b1;
    #1 chk(lockGrant, 1'b0);
    lockedCount = 7'd62;
    #1 chk(lockGrant, 1'b1);
    for (int p = 8; p < 16; p++) begin
      wtc($urandom);
      wtc({6'h20, 2'($urandom), 4'(p), 8'h0f, 4'(17 - p), 8'h00});
      walk = 2'($urandom);
      #1 chk(pageSize, tcM[23:20]);
      chk(initialShift, tcM[19:16]);
      chk(firstIndexTop, 31 - tcM[19:16]);
      chk(levelWidths, tcM[15:0]);
      chk(fcLookupFirst, tcM[24] || walk.dmaRoot);
      if (!walk.dmaRoot) chk(useSupervisorRoot, tcM[25] && walk.supervisor);
    end
    wtc(32'h80f0f0f0);
    mtc_host_i.xfer(MTC_OP_MOVE, 1'b1, REG_CUR_LEVEL, $urandom);
    curM = mtc_host_i.req.data[7:0] & 8'he0;
    ops();
    levelCheckEn = 1'b1;
    for (int a = 0; a < 8; a++) begin
      @(negedge core_clk) addrLevel = 3'(a);
      #1 chk(busAbort, a < curM[7:5]);
    end
    wtc(32'h0);
    wtc(32'h808ff000);
    wtc(32'h8070fa00);
    final_report();
  end
endmodule
